//--- logic/fault_status_bytes.sv
/*
  Three one-byte fault status registers (output voltage and output current,
  paged per channel; input, shared) with write-one-to-clear latched flags.
  Assumes the bus logic decodes Read Byte / Write Byte into one-cycle
  strobes with command code and page, and that fault inputs are
  synchronous one-cycle or level detections from protection logic.
*/
`timescale 1ns/1ps
`default_nettype none

module fault_status_bytes
  import fault_status_pkg::*;
(
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic rd_stb,
  input wire logic wr_stb,
  input wire logic [7:0] cmd_code,
  input wire logic [7:0] page,
  input wire logic [7:0] wr_data,
  input wire logic [1:0] output_overvoltage_fault,
  input wire logic [1:0] output_undervoltage_fault,
  input wire logic [1:0] output_setpoint_limit_warning,
  input wire logic [1:0] output_overcurrent_fault,
  input wire logic [1:0] output_overcurrent_warning,
  input wire logic [1:0] phase_sharing_fault,
  input wire logic input_overvoltage_fault,
  input wire logic input_undervoltage_fault,
  input wire logic insufficient_input_off,
  input wire logic input_overcurrent_fault,
  input wire logic input_overcurrent_warning,
  input wire logic input_overpower_warning,
  output logic [7:0] rd_data,
  output logic rd_valid,
  output logic cmd_hit,
  output logic [1:0] summary_vout,
  output logic [1:0] summary_iout,
  output logic summary_input
);

  typedef struct packed {
    logic [1:0][7:0] vout;
    logic [1:0][7:0] iout;
    logic [7:0] inp;
    logic [7:0] rd_data;
    logic rd_valid;
    logic hit;
    logic [1:0] sum_v;
    logic [1:0] sum_i;
    logic sum_n;
  } state_t;

  state_t st_r;
  state_t st_nxt;

  // Page to channel index; FFh and any other value fall back to A
  function automatic logic page_chan(input logic [7:0] pg);
    page_chan = (pg == PAGE_CHAN_B);
  endfunction

  // Set wins over clear so no event in the clearing cycle is lost
  function automatic logic [7:0] update(input logic [7:0] cur, input logic [7:0] set,
                                        input logic [7:0] clr, input logic [7:0] mask);
    update = ((cur & ~clr) | set) & mask;
  endfunction

  logic chan;
  logic is_vout;
  logic is_iout;
  logic is_inp;
  logic [1:0][7:0] vset;
  logic [1:0][7:0] iset;
  logic [7:0] inset;

  assign chan = page_chan(page);
  assign is_vout = (cmd_code == CMD_VOUT_STATUS);
  assign is_iout = (cmd_code == CMD_IOUT_STATUS);
  assign is_inp = (cmd_code == CMD_INPUT_STATUS);

  always_comb
  begin
    for (int c = 0; c < 2; c++)
    begin
      vset[c] = 8'h00;
      vset[c][OV_FLAG_BIT] = output_overvoltage_fault[c];
      vset[c][UV_FLAG_BIT] = output_undervoltage_fault[c];
      vset[c][VOUT_LIMIT_BIT] = output_setpoint_limit_warning[c];
      iset[c] = 8'h00;
      iset[c][OC_FLAG_BIT] = output_overcurrent_fault[c];
      iset[c][OC_WARN_BIT] = output_overcurrent_warning[c];
      iset[c][IOUT_SHARE_BIT] = phase_sharing_fault[c];
    end
    inset = {input_overvoltage_fault, 2'h0, input_undervoltage_fault, insufficient_input_off,
             input_overcurrent_fault, input_overcurrent_warning,
             input_overpower_warning};
  end

  always_comb
  begin
    logic [7:0] vclr;
    logic [7:0] iclr;
    logic [7:0] nclr;
    st_nxt = st_r;
    vclr = 8'h00;
    iclr = 8'h00;
    nclr = 8'h00;
    // Only ones clear; zeros in the write byte leave flags alone
    if (wr_stb && is_vout)
      vclr = wr_data;
    if (wr_stb && is_iout)
      iclr = wr_data;
    if (wr_stb && is_inp)
      nclr = wr_data;
    for (int c = 0; c < 2; c++)
    begin
      // Conditions still present re-latch on the same edge
      st_nxt.vout[c] = update(st_r.vout[c], vset[c],
                              (chan == c[0]) ? vclr : 8'h00, VOUT_SUPPORTED);
      st_nxt.iout[c] = update(st_r.iout[c], iset[c],
                              (chan == c[0]) ? iclr : 8'h00, IOUT_SUPPORTED);
    end
    st_nxt.inp = update(st_r.inp, inset, nclr, INPUT_SUPPORTED);
    // Summary taken from the next flags, so it moves on the same edge
    st_nxt.sum_v = {|st_nxt.vout[1], |st_nxt.vout[0]};
    st_nxt.sum_i = {|st_nxt.iout[1], |st_nxt.iout[0]};
    st_nxt.sum_n = |st_nxt.inp;
    st_nxt.rd_valid = 1'b0;
    st_nxt.hit = 1'b0;
    if (rd_stb || wr_stb)
      st_nxt.hit = is_vout || is_iout || is_inp;
    if (rd_stb)
    begin
      st_nxt.rd_valid = 1'b1;
      if (is_vout)
        st_nxt.rd_data = st_r.vout[chan];
      else if (is_iout)
        st_nxt.rd_data = st_r.iout[chan];
      else if (is_inp)
        st_nxt.rd_data = st_r.inp;
      else
        st_nxt.rd_data = 8'h00;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      st_r <= '0;
      st_r.vout <= {STATUS_RESET, STATUS_RESET};
      st_r.iout <= {STATUS_RESET, STATUS_RESET};
      st_r.inp <= STATUS_RESET;
    end
    else
      st_r <= st_nxt;
  end

  assign rd_data = st_r.rd_data;
  assign rd_valid = st_r.rd_valid;
  assign cmd_hit = st_r.hit;
  // Summary bits are the OR of latched flags, so clearing here clears them
  assign summary_vout = st_r.sum_v;
  assign summary_iout = st_r.sum_i;
  assign summary_input = st_r.sum_n;

  sequence s_wr_ones_vout_a;
    wr_stb && is_vout && !chan && wr_data[OV_FLAG_BIT] && !output_overvoltage_fault[0];
  endsequence

  a_ovf_latch: assert property (@(posedge ref_clk) disable iff (srst)
    output_overvoltage_fault[0] |=> st_r.vout[0][OV_FLAG_BIT])
    else $error("over-voltage flag did not latch");
  a_uvf_latch: assert property (@(posedge ref_clk) disable iff (srst)
    output_undervoltage_fault[1] |=> st_r.vout[1][UV_FLAG_BIT])
    else $error("under-voltage flag did not latch");
  a_limit_latch: assert property (@(posedge ref_clk) disable iff (srst)
    output_setpoint_limit_warning[0] |=> st_r.vout[0][VOUT_LIMIT_BIT])
    else $error("setpoint limit flag did not latch");
  a_ocf_latch: assert property (@(posedge ref_clk) disable iff (srst)
    output_overcurrent_fault[1] |=> st_r.iout[1][OC_FLAG_BIT] && summary_iout[1])
    else $error("over-current flag did not latch");
  a_ocw_latch: assert property (@(posedge ref_clk) disable iff (srst)
    output_overcurrent_warning[0] |=> st_r.iout[0][OC_WARN_BIT])
    else $error("over-current warning did not latch");
  a_share_latch: assert property (@(posedge ref_clk) disable iff (srst)
    phase_sharing_fault[0] |=> st_r.iout[0][IOUT_SHARE_BIT])
    else $error("sharing flag did not latch");
  a_unsup_zero: assert property (@(posedge ref_clk) disable iff (srst)
    rd_valid |-> !((rd_data & ~(VOUT_SUPPORTED | IOUT_SUPPORTED | INPUT_SUPPORTED)) != 8'h00))
    else $error("unsupported bit read as one");
  a_w1c_clear: assert property (@(posedge ref_clk) disable iff (srst)
    s_wr_ones_vout_a |=> !st_r.vout[0][OV_FLAG_BIT])
    else $error("write one did not clear flag");
  a_page_ff_read: assert property (@(posedge ref_clk) disable iff (srst)
    rd_stb && is_iout && page == PAGE_ALL |=> rd_data == $past(st_r.iout[0]))
    else $error("page FFh did not read channel A");
  a_flag_holds: assert property (@(posedge ref_clk) disable iff (srst)
    st_r.inp[0] && !(wr_stb && is_inp && wr_data[0]) |=> st_r.inp[0])
    else $error("input flag dropped without clear");
  a_set_wins: assert property (@(posedge ref_clk) disable iff (srst)
    wr_stb && is_inp && wr_data[7] && input_overvoltage_fault |=> st_r.inp[7])
    else $error("persisting condition lost on clear");

endmodule

`default_nettype wire

//--- logic/fault_status_pkg.sv
/*
  Constants for the fault status byte bank: command codes, page values,
  bit positions and reset values.
  Assumes a byte-wide command port driven by the bus interface logic.
*/
package fault_status_pkg;
  localparam logic [7:0] CMD_VOUT_STATUS = 8'h7a;
  localparam logic [7:0] CMD_IOUT_STATUS = 8'h7b;
  localparam logic [7:0] CMD_INPUT_STATUS = 8'h7c;
  localparam logic [7:0] PAGE_CHAN_A = 8'h00;
  localparam logic [7:0] PAGE_CHAN_B = 8'h01;
  localparam logic [7:0] PAGE_ALL = 8'hff;
  localparam logic [7:0] VOUT_SUPPORTED = 8'h98;
  localparam logic [7:0] IOUT_SUPPORTED = 8'ha8;
  localparam logic [7:0] INPUT_SUPPORTED = 8'h9f;
  localparam int OV_FLAG_BIT = 7;
  localparam int UV_FLAG_BIT = 4;
  localparam int VOUT_LIMIT_BIT = 3;
  localparam int OC_FLAG_BIT = 7;
  localparam int OC_WARN_BIT = 5;
  localparam int IOUT_SHARE_BIT = 3;
  localparam logic [7:0] STATUS_RESET = 8'h00;
endpackage

//--- tb/fault_status_bytes_tb.sv
/* Self-checking bench for the fault status bytes.
   Assumes the host model and the design package. */
`timescale 1ns/1ps
`default_nettype none
module fault_status_bytes_tb;
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  logic inj = 1'b0;
  logic rd_stb, wr_stb, rd_valid, cmd_hit, summary_input, exp_v, exp_hit;
  logic [7:0] cmd_code, page, wr_data, rd_data;
  logic [1:0] ov = 2'h0, uv = 2'h0, sl = 2'h0, oc = 2'h0, ow = 2'h0, ps = 2'h0;
  logic [1:0] summary_vout, summary_iout;
  logic [5:0] fin = 6'h00;
  logic [4:0] exp_sum;
  logic [7:0] codes[5] = '{8'h7a, 8'h7b, 8'h7c, 8'h79, 8'h7d};
  logic [7:0] pages[3] = '{8'h00, 8'h01, 8'hff};
  int mv[2], mi[2], mn, exp_rd, n_errors, cmp_count;
  always #10 ref_clk = ~ref_clk;
  pmbus_host_model host (.ref_clk(ref_clk), .rd_stb(rd_stb), .wr_stb(wr_stb),
    .cmd_code(cmd_code), .page(page), .wr_data(wr_data));
  fault_status_bytes DUT (.ref_clk(ref_clk), .srst(srst), .rd_stb(rd_stb), .wr_stb(wr_stb),
    .cmd_code(cmd_code), .page(page), .wr_data(wr_data), .output_overvoltage_fault(ov),
    .output_undervoltage_fault(uv), .output_setpoint_limit_warning(sl),
    .output_overcurrent_fault(oc), .output_overcurrent_warning(ow), .phase_sharing_fault(ps),
    .input_overvoltage_fault(fin[5]), .input_undervoltage_fault(fin[4]),
    .insufficient_input_off(fin[3]), .input_overcurrent_fault(fin[2]),
    .input_overcurrent_warning(fin[1]), .input_overpower_warning(fin[0]), .rd_data(rd_data),
    .rd_valid(rd_valid), .cmd_hit(cmd_hit), .summary_vout(summary_vout),
    .summary_iout(summary_iout), .summary_input(summary_input));
  function automatic logic [7:0] sparse();
    return 8'($urandom & $urandom & $urandom);
  endfunction
  // Sparse detections so flags are seen both set and cleared
  always @(posedge ref_clk)
  begin
    {ov, uv, sl, oc, ow, ps} <= inj ? 12'({sparse(), sparse()}) : 12'h000;
    fin <= inj ? 6'(sparse()) : 6'h00;
  end
  // Read sees old flags; detection wins over clear
  always @(posedge ref_clk)
  begin
    automatic int ch = (page == 8'h01);
    exp_v = rd_stb;
    exp_hit = (rd_stb | wr_stb) && cmd_code inside {8'h7a, 8'h7b, 8'h7c};
    if (rd_stb)
      exp_rd = cmd_code == 8'h7a ? mv[ch] : cmd_code == 8'h7b ? mi[ch] :
        cmd_code == 8'h7c ? mn : 0;
    if (wr_stb && cmd_code == 8'h7a) mv[ch] &= ~(wr_data & 8'h98);
    if (wr_stb && cmd_code == 8'h7b) mi[ch] &= ~(wr_data & 8'ha8);
    if (wr_stb && cmd_code == 8'h7c) mn &= ~(wr_data & 8'h9f);
    for (int c = 0; c < 2; c++)
    begin
      mv[c] |= {ov[c], 2'b00, uv[c], sl[c], 3'b000};
      mi[c] |= {oc[c], 1'b0, ow[c], 1'b0, ps[c], 3'b000};
    end
    mn |= {fin[5], 2'b00, fin[4:0]};
    if (srst)
    begin
      mv = '{0, 0};
      mi = '{0, 0};
      mn = 0;
      exp_v = 1'b0;
      exp_hit = 1'b0;
    end
  end
  task automatic cmp(input logic [7:0] seen, input logic [7:0] exp, input string what);
    cmp_count++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  always @(negedge ref_clk)
    if (!srst)
    begin
      cmp(8'(rd_valid), 8'(exp_v), "rd_valid");
      cmp(8'(cmd_hit), 8'(exp_hit), "cmd_hit");
      if (exp_v) cmp(rd_data, 8'(exp_rd), "rd_data");
    end
  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial
  begin
    void'($urandom(32'ha023));
    repeat (8) @(posedge ref_clk);
    srst <= 1'b0;
    for (int i = 0; i < 400; i++)
    begin
      inj <= 1'b1;
      host.xfer(1'b0, codes[$urandom % 5], pages[$urandom % 3], 8'h00);
      host.xfer(1'b1, codes[$urandom % 5], pages[$urandom % 3], 8'($urandom));
      if (i % 8 == 0)
      begin
        inj <= 1'b0;
        repeat (3) @(negedge ref_clk);
        exp_sum = {mn != 0, mi[1] != 0, mi[0] != 0, mv[1] != 0, mv[0] != 0};
        cmp(8'({summary_input, summary_iout, summary_vout}), 8'(exp_sum), "summary");
      end
      // Second reset mid-run must wipe every flag
      srst <= (i == 200);
    end
    close_out();
  end
  initial
  begin
    #200000;
    n_errors++;
    close_out();
  end
endmodule
`default_nettype wire

//--- tb/pmbus_host_model.sv
/* Host side: issues Read Byte and Write Byte requests as strobes.
   Assumes one clock shared with the status bank. */
`timescale 1ns/1ps
`default_nettype none
module pmbus_host_model (
  input wire logic ref_clk,
  output logic rd_stb,
  output logic wr_stb,
  output logic [7:0] cmd_code,
  output logic [7:0] page,
  output logic [7:0] wr_data
);
  initial
  begin
    rd_stb = 1'b0;
    wr_stb = 1'b0;
    cmd_code = 8'h00;
    page = 8'h00;
    wr_data = 8'h00;
  end
  task automatic xfer(input logic wr, input logic [7:0] c, input logic [7:0] p,
    input logic [7:0] d);
    @(posedge ref_clk);
    rd_stb <= ~wr;
    wr_stb <= wr;
    cmd_code <= c;
    page <= p;
    wr_data <= d;
    @(posedge ref_clk);
    rd_stb <= 1'b0;
    wr_stb <= 1'b0;
    // Idle bus shows no stale command
    cmd_code <= ~c;
    wr_data <= ~d;
  endtask
endmodule
`default_nettype wire
